/* rtl/bcc_clock.v */
// BCD clock and calendar reached as a two-wire serial bus slave.
//
// What this block does
// RULE1: Time and date digits are held as binary-coded decimal.
// RULE2: Seconds, minutes, hours, day, date, month, year counters carry onward.
// RULE3: Date rolls after the real last day of each month.
// RULE4: Every year divisible by four is a leap year.
// RULE5: Hours run in 24-hour or 12-hour format with afternoon flag.
// RULE6: Fifty-six bytes of storage retain their contents.
// RULE7: Slave only; master sends START, slave identity, then register address.
// RULE8: Pointer advances after each byte until STOP.
// RULE9: Power-fail lockout aborts any transfer in progress.
// RULE10: Power-fail lockout clears the register pointer.
// RULE11: While locked out, all bus input is ignored.
// RULE12: Below backup voltage, battery mode keeps only time and storage.
// RULE13: Above backup plus margin, battery mode ends.
// RULE14: Bus input accepted again only once the lockout releases.
// RULE15: Pointer wraps from 3Fh back to 00h.
// RULE16: Seconds bit 7 set halts timekeeping.
// RULE17: Hours bit 6 selects 12-hour; bit 5 is afternoon or tens.
// RULE18: Each START copies time into a read shadow set.
// RULE19: Seconds and minutes count 00 to 59 and carry on wrap.
`timescale 1ns/1ns
`default_nettype none
`include "bcc_defines.vh"

module bcc_clock (
	// Clock and reset.
	input wire clk,
	input wire rst,
	// Serial bus pins; sda output enable is low while pulling low.
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n,
	// Supply comparators from the analog front end.
	input wire supply_lockout,
	input wire supply_battery,
	// Status and control bits.
	output reg battery_mode,
	output reg bus_locked,
	output reg oscillator_halt,
	output reg [7:0] control_reg
);

	// State codes, one-hot.
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_RECV = 5'h02;
	localparam [4:0] ST_ACK = 5'h04;
	localparam [4:0] ST_SEND = 5'h08;
	localparam [4:0] ST_RACK = 5'h10;

	// Synchronised pins.
	wire scl;
	wire sda;
	wire lock_s;
	wire batt_s;
	bcc_sync #(.W(4)) u_sync (
		.clk(clk),
		.d({scl_in, sda_in, supply_lockout, supply_battery}),
		.q({scl, sda, lock_s, batt_s})
	);

	// Time registers and shadows.
	reg [7:0] sec, min, hour, day, date, mon, year;
	reg [7:0] sh [0:6];
	reg [`BCC_TICK_W-1:0] tick_cnt;
	reg scl_d, sda_d;
	reg [4:0] state;
	reg [2:0] bitn;
	reg [7:0] shreg;
	reg [5:0] ptr;
	reg first_byte, addr_phase, is_read, ram_wr;
	reg [7:0] ram_wdata;
	reg [5:0] ram_waddr;
	wire [7:0] ram_rdata;
	integer i;

	// RULE6: storage array
	bcc_ram u_ram (
		.clk(clk),
		.wr_en(ram_wr),
		.wr_addr(ram_waddr),
		.wr_data(ram_wdata),
		.rd_addr(ptr),
		.rd_data(ram_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// BCD helpers.
	// RULE1: decimal digit step
	function [7:0] bcd_inc;
		input [7:0] v;
		begin
			if (v[3:0] == 4'h9)
				bcd_inc = {v[7:4] + 4'h1, 4'h0};
			else
				bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	// RULE3: month length
	// RULE4: leap years
	function [7:0] last_day;
		input [7:0] m;
		input [7:0] y;
		begin
			case (m)
				8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
				`BCC_MON_FEB: last_day =
					((y[4] ^ y[1]) | y[0]) ? 8'h28 : 8'h29;
				default: last_day = 8'h31;
			endcase
		end
	endfunction

	// Register view of the shadow set, control register and storage, used for reads.
	function [7:0] rd_view;
		input [5:0] a;
		begin
			if (a <= `BCC_ADDR_YEAR)
				rd_view = sh[a[2:0]];
			else if (a == `BCC_ADDR_CTRL)
				rd_view = control_reg;
			else
				rd_view = ram_rdata;
		end
	endfunction

	// Bus conditions seen on the synchronised pins.
	wire start_c = scl & scl_d & sda_d & ~sda;
	wire stop_c = scl & scl_d & ~sda_d & sda;
	wire scl_rise = scl & ~scl_d;
	wire scl_fall = ~scl & scl_d;
	wire tick = (tick_cnt == `BCC_TICK_CYCLES - 1);
	// Only the first fall of a data byte's acknowledge slot writes.
	wire bus_write = (state == ST_ACK) && scl_fall && sda_oe_n &&
		!addr_phase && !first_byte && !is_read && !lock_s && !batt_s;
	wire [7:0] hr_12 = {3'h0, hour[4:0]};
	// Function results cannot be bit-selected, so they pass through nets.
	wire [7:0] hr12_next = bcd_inc(hr_12);
	wire [7:0] hr24_next = bcd_inc({2'h0, hour[5:0]});
	wire [7:0] rd_byte = rd_view(ptr);

	////////////////////////////////////////////////////////////////////////
	// Timekeeping runs in every supply mode; only the halt bit stops it.
	always @(posedge clk) begin
		if (rst) begin
			tick_cnt <= {`BCC_TICK_W{1'b0}};
			sec <= `BCC_RST_ZERO;
			min <= `BCC_RST_ZERO;
			hour <= `BCC_RST_ZERO;
			day <= `BCC_RST_DAY;
			date <= `BCC_RST_DATE;
			mon <= `BCC_RST_MON;
			year <= `BCC_RST_ZERO;
		end else if (bus_write && ptr <= `BCC_ADDR_YEAR) begin
			// A write resets the sub-second divider so set time is exact.
			tick_cnt <= {`BCC_TICK_W{1'b0}};
			case (ptr)
				`BCC_ADDR_SEC: sec <= shreg;
				`BCC_ADDR_MIN: min <= shreg;
				`BCC_ADDR_HOUR: hour <= shreg;
				`BCC_ADDR_DAY: day <= shreg;
				`BCC_ADDR_DATE: date <= shreg;
				`BCC_ADDR_MON: mon <= shreg;
				default: year <= shreg;
			endcase
		// RULE16: halt stops counting
		end else if (!sec[`BCC_BIT_HALT]) begin
			tick_cnt <= tick ? {`BCC_TICK_W{1'b0}} :
				tick_cnt + 1'b1;
			// RULE2: carry chain
			// RULE19: seconds and minutes wrap
			if (tick) begin
				sec <= (sec == `BCC_MAX_SEC) ? `BCC_RST_ZERO : bcd_inc(sec);
				if (sec == `BCC_MAX_SEC) begin
					min <= (min == `BCC_MAX_SEC) ? `BCC_RST_ZERO :
						bcd_inc(min);
				end
				if (sec == `BCC_MAX_SEC && min == `BCC_MAX_SEC) begin
					// RULE5: two hour formats
					// RULE17: mode and afternoon bits
					if (hour[`BCC_BIT_12H]) begin
						if (hr_12[4:0] == `BCC_MAX_HOUR12)
							hour <= {hour[7:5], 5'h01};
						else if (hr_12[4:0] == 5'h11)
							hour <= {hour[7:6], ~hour[5], 5'h12};
						else
							hour <= {hour[7:5], hr12_next[4:0]};
					end else if (hour[5:0] == `BCC_MAX_HOUR24) begin
						hour <= {hour[7:6], 6'h00};
					end else begin
						hour <= {hour[7:6], hr24_next[5:0]};
					end
				end
				// Day rollover: 23:59:59 or 11:59:59 PM.
				if (sec == `BCC_MAX_SEC && min == `BCC_MAX_SEC &&
					(hour[`BCC_BIT_12H] ? (hour[5] &&
					hr_12[4:0] == 5'h11) :
					hour[5:0] == `BCC_MAX_HOUR24)) begin
					day <= (day == `BCC_MAX_DAY) ? `BCC_RST_DAY :
						bcd_inc(day);
					// RULE3: month end
					if (date == last_day(mon, year)) begin
						date <= `BCC_RST_DATE;
						mon <= (mon == `BCC_MAX_MON) ? `BCC_RST_MON :
							bcd_inc(mon);
						if (mon == `BCC_MAX_MON)
							year <= (year == `BCC_MAX_YEAR) ?
								`BCC_RST_ZERO : bcd_inc(year);
					end else begin
						date <= bcd_inc(date);
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial slave. Lockout takes priority over every bus event.
	always @(posedge clk) begin
		if (rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			state <= ST_IDLE;
			bitn <= 3'h0;
			shreg <= 8'h00;
			ptr <= `BCC_ADDR_FIRST;
			first_byte <= 1'b0;
			addr_phase <= 1'b0;
			is_read <= 1'b0;
			sda_out <= 1'b1;
			sda_oe_n <= 1'b1;
			ram_wr <= 1'b0;
			ram_wdata <= 8'h00;
			ram_waddr <= 6'h00;
			control_reg <= 8'h00;
			for (i = 0; i < 7; i = i + 1)
				sh[i] <= 8'h00;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
			ram_wr <= 1'b0;
			// RULE9: abort transfer
			// RULE10: pointer cleared
			// RULE11: input ignored
			// RULE14: release only on comparator
			// Battery mode sits below the lockout level, so it locks too.
			if (lock_s || batt_s) begin
				state <= ST_IDLE;
				ptr <= `BCC_ADDR_FIRST;
				sda_oe_n <= 1'b1;
				sda_out <= 1'b1;
			// RULE7: start of access
			end else if (start_c) begin
				state <= ST_RECV;
				bitn <= 3'h0;
				first_byte <= 1'b1;
				addr_phase <= 1'b0;
				sda_oe_n <= 1'b1;
				// RULE18: shadow copy
				sh[0] <= sec;
				sh[1] <= min;
				sh[2] <= hour;
				sh[3] <= day;
				sh[4] <= date;
				sh[5] <= mon;
				sh[6] <= year;
			end else if (stop_c) begin
				state <= ST_IDLE;
				sda_oe_n <= 1'b1;
			end else begin
				case (state)
					ST_IDLE: sda_oe_n <= 1'b1;
					ST_RECV: if (scl_rise) begin
						shreg <= {shreg[6:0], sda};
						bitn <= bitn + 3'h1;
						if (bitn == 3'h7)
							state <= ST_ACK;
					end
					ST_ACK: if (scl_fall) begin
						if (!sda_oe_n || (is_read && !first_byte)) begin
							// Slot over, or the master acknowledged a read.
							if (is_read) begin
								state <= ST_SEND;
								sda_out <= rd_byte[7];
								shreg <= {rd_byte[6:0], 1'b0};
								sda_oe_n <= rd_byte[7];
								bitn <= 3'h1;
							end else begin
								sda_out <= 1'b1;
								sda_oe_n <= 1'b1;
								state <= ST_RECV;
							end
						end else if (first_byte) begin
							if (shreg[7:1] == `BCC_SLAVE_ID) begin
								first_byte <= 1'b0;
								is_read <= shreg[0];
								addr_phase <= ~shreg[0];
								sda_out <= 1'b0;
								sda_oe_n <= 1'b0;
							end else begin
								state <= ST_IDLE;
							end
						end else begin
							// Register address or data byte received; acknowledge it.
							sda_out <= 1'b0;
							sda_oe_n <= 1'b0;
							if (addr_phase) begin
								ptr <= shreg[5:0];
								addr_phase <= 1'b0;
							end else begin
								if (ptr == `BCC_ADDR_CTRL)
									control_reg <= shreg;
								else if (ptr > `BCC_ADDR_CTRL)
									ram_wr <= 1'b1;
								ram_waddr <= ptr;
								ram_wdata <= shreg;
								// RULE8: advance pointer
								// RULE15: wrap at end
								ptr <= ptr + 6'h01;
							end
						end
					end
					ST_SEND: if (scl_fall) begin
						if (bitn == 3'h0) begin
							sda_oe_n <= 1'b1;
							ptr <= ptr + 6'h01;
							state <= ST_RACK;
						end else begin
							sda_oe_n <= shreg[7];
							sda_out <= shreg[7];
							shreg <= {shreg[6:0], 1'b0};
							bitn <= bitn + 3'h1;
						end
					end
					ST_RACK: if (scl_rise) begin
						state <= sda ? ST_IDLE : ST_ACK;
					end
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status outputs.
	always @(posedge clk) begin
		if (rst) begin
			battery_mode <= 1'b0;
			bus_locked <= 1'b0;
			oscillator_halt <= 1'b0;
		end else begin
			// RULE12: enter battery mode
			// RULE13: leave battery mode
			battery_mode <= batt_s;
			bus_locked <= lock_s;
			oscillator_halt <= sec[`BCC_BIT_HALT];
		end
	end

endmodule // bcc_clock

`default_nettype wire

/* rtl/bcc_defines.vh */
// Named constants shared by the clock and calendar serial slave.
`ifndef BCC_DEFINES_VH
`define BCC_DEFINES_VH

// Register map.
`define BCC_ADDR_SEC 6'h00
`define BCC_ADDR_MIN 6'h01
`define BCC_ADDR_HOUR 6'h02
`define BCC_ADDR_DAY 6'h03
`define BCC_ADDR_DATE 6'h04
`define BCC_ADDR_MON 6'h05
`define BCC_ADDR_YEAR 6'h06
`define BCC_ADDR_CTRL 6'h07
`define BCC_ADDR_LAST 6'h3f
`define BCC_ADDR_FIRST 6'h00

// Field positions.
`define BCC_BIT_HALT 7
`define BCC_BIT_12H 6
`define BCC_BIT_PM 5

// Slave identity on the serial bus; the value is arbitrary.
`define BCC_SLAVE_ID 7'h5a

// Tick divider: 100 MHz core clock, one-second tick.
`define BCC_CLK_HZ 100000000
`define BCC_TICK_HZ 1
`define BCC_TICK_CYCLES (`BCC_CLK_HZ / `BCC_TICK_HZ)
`define BCC_TICK_W 27

// Reset values of the calendar after reset.
`define BCC_RST_DAY 8'h01
`define BCC_RST_DATE 8'h01
`define BCC_RST_MON 8'h01
`define BCC_RST_ZERO 8'h00

// Limits of the BCD counters.
`define BCC_MAX_SEC 8'h59
`define BCC_MAX_HOUR24 8'h23
`define BCC_MAX_HOUR12 5'h12
`define BCC_MAX_DAY 8'h07
`define BCC_MAX_MON 8'h12
`define BCC_MAX_YEAR 8'h99
`define BCC_MON_FEB 8'h02

`endif

/* rtl/bcc_ram.v */
// Retained general-purpose storage with a registered read port.
`timescale 1ns/1ns
`default_nettype none

module bcc_ram (
	// Clock.
	input wire clk,
	// Write port.
	input wire wr_en,
	input wire [5:0] wr_addr,
	input wire [7:0] wr_data,
	// Read port.
	input wire [5:0] rd_addr,
	output reg [7:0] rd_data
);

	// Full 64-entry array; the clock registers below 08h shadow it unused.
	reg [7:0] mem [0:63];

	////////////////////////////////////////////////////////////////////////
	// Registered read and plain write; no reset so contents survive.
	always @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule // bcc_ram

`default_nettype wire

/* rtl/bcc_sync.v */
// Two-flip-flop synchroniser for levels entering from outside the domain.
`timescale 1ns/1ns
`default_nettype none

module bcc_sync #(
	parameter W = 1
) (
	// Clock.
	input wire clk,
	// Asynchronous level in, synchronised level out.
	input wire [W-1:0] d,
	output reg [W-1:0] q
);

	reg [W-1:0] meta;

	////////////////////////////////////////////////////////////////////////
	// Only the second stage reads the first.
	always @(posedge clk) begin
		meta <= d;
		q <= meta;
	end

endmodule // bcc_sync

`default_nettype wire

/* test/bcc_clock_bench.sv */
// Self-checking bench for the clock and calendar serial slave.
`timescale 1ns/1ns
`default_nettype none
`include "bcc_defines.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
	n_mismatch++; $display("[ERR] %0t got %h want %h", $time, a, b); end end

module bcc_clock_bench;
	logic clk, rst, supply_lockout, supply_battery;
	wire scl_in, sda_m, res_valid, sda_out, sda_oe_n;
	wire battery_mode, bus_locked, oscillator_halt;
	wire [7:0] res, control_reg;
	// Pull-up on the data wire; the slave can only pull it low.
	wire sda_in = sda_m & (sda_oe_n | sda_out);
	int seed = 44242;
	int n_mismatch = 0;
	int num_checks = 0;
	logic [7:0] q[$];
	logic [7:0] dat[64];
	logic [7:0] e;
	logic [63:0] cal = 64'h45_59_72_07_31_12_99_93;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	bcc_clock dut (.clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe_n,
		.supply_lockout, .supply_battery, .battery_mode, .bus_locked,
		.oscillator_halt, .control_reg);
	bcc_master m (.clk, .scl(scl_in), .sda_m, .sda(sda_in), .res_valid,
		.res);

	// Address phase; every acknowledge is noted before it is sent.
	task addr(input logic [5:0] a);
		q.push_back(8'h01);
		q.push_back(8'h01);
		m.start();
		m.xbyte({`BCC_SLAVE_ID, 1'b0}, 1'b0, 1'b0);
		m.xbyte({2'b00, a}, 1'b0, 1'b0);
	endtask

	task wr(input logic [5:0] a, input int n);
		addr(a);
		for (int i = 0; i < n; i++) begin
			q.push_back(8'h01);
			m.xbyte(dat[a + 6'(i)], 1'b0, 1'b0);
		end
		m.stop();
	endtask

	// Reads start at the pointer unless set is given.
	task rd(input logic [5:0] a, input int n, input logic set);
		if (set) begin
			addr(a);
			m.stop();
		end
		q.push_back(8'h01);
		m.start();
		m.xbyte({`BCC_SLAVE_ID, 1'b1}, 1'b0, 1'b0);
		for (int i = 0; i < n; i++) begin
			q.push_back(dat[a + 6'(i)]);
			m.xbyte(8'hff, 1'b1, i == n - 1);
		end
		m.stop();
	endtask

	task report_and_stop;
		if (q.size() != 0) n_mismatch++;
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Each byte result is matched against the oldest note.
	always @(posedge clk) begin
		if (res_valid === 1'b1) begin
			e = q.pop_front();
			`CHK(res, e)
		end
	end

	initial begin
		#500000;
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		supply_lockout = 1'b0;
		supply_battery = 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		for (int i = 0; i < 64; i++) dat[i] = $random(seed);
		for (int i = 0; i < 8; i++) dat[i] = cal[63 - 8 * i -: 8];
		dat[0] = 8'h80;
		dat[2] = 8'h23;
		wr(6'h3e, 3);
		`CHK(oscillator_halt, 1'b1)
		rd(6'h3e, 3, 1'b1);
		wr(6'h02, 1);
		rd(6'h02, 1, 1'b1);
		// full map, then read on from the wrapped pointer.
		dat[0] = 8'h45;
		dat[2] = 8'h72;
		wr(6'h00, 64);
		`CHK(oscillator_halt, 1'b0)
		`CHK(control_reg, 8'h93)
		rd(6'h00, 64, 1'b0);
		q.push_back(8'h00);
		m.start();
		m.xbyte({`BCC_SLAVE_ID ^ 7'h01, 1'b0}, 1'b0, 1'b0);
		m.stop();
		// lockout ignores the bus and clears the pointer.
		addr(6'h07);
		m.stop();
		supply_lockout <= 1'b1;
		m.wt(8);
		`CHK(bus_locked, 1'b1)
		// A locked write of a fresh control value must leave no trace.
		repeat (3) q.push_back(8'h00);
		m.start();
		m.xbyte({`BCC_SLAVE_ID, 1'b0}, 1'b0, 1'b0);
		m.xbyte({2'b00, `BCC_ADDR_CTRL}, 1'b0, 1'b0);
		m.xbyte(8'h6c, 1'b0, 1'b0);
		m.stop();
		`CHK(control_reg, 8'h93)
		// Random supply wobble while locked, then battery mode proper.
		repeat (4) begin
			supply_battery <= 1'($random(seed));
			m.wt(6);
		end
		supply_battery <= 1'b1;
		m.wt(8);
		`CHK(battery_mode, 1'b1)
		supply_battery <= 1'b0;
		m.wt(8);
		`CHK(battery_mode, 1'b0)
		supply_lockout <= 1'b0;
		m.wt(8);
		`CHK(bus_locked, 1'b0)
		rd(6'h00, 1, 1'b0);
		report_and_stop();
	end
endmodule // bcc_clock_bench

`default_nettype wire

/* test/bcc_clock_chk.sv */
// Pin-level checker for the clock and calendar serial slave.
`timescale 1ns/1ns
`default_nettype none

module bcc_clock_chk (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Serial and supply pins.
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic supply_lockout,
	input wire logic supply_battery,
	// Status outputs.
	input wire logic battery_mode,
	input wire logic bus_locked,
	input wire logic oscillator_halt,
	input wire logic [7:0] control_reg
);
	// Flags lag their inputs by three cycles, so four samples just cover it.
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	lock_on_a: assert property (supply_lockout [*4] |-> bus_locked)
		else $error("lockout flag late");
	lock_off_a: assert property (!supply_lockout [*4] |-> !bus_locked)
		else $error("lockout flag stuck");
	batt_on_a: assert property (supply_battery [*4] |-> battery_mode)
		else $error("battery flag late");
	batt_off_a: assert property (!supply_battery [*4] |-> !battery_mode)
		else $error("battery flag stuck");
	// no drive and no writes while locked.
	lock_quiet_a: assert property (bus_locked && $past(bus_locked) |-> sda_oe_n)
		else $error("drives bus while locked");
	lock_hold_a: assert property (bus_locked && $past(bus_locked)
		|=> $stable(control_reg) && $stable(oscillator_halt))
		else $error("register written while locked");
	batt_quiet_a: assert property (battery_mode |-> sda_oe_n)
		else $error("drives bus in battery mode");
	// open-drain data pin only pulls low.
	pull_low_a: assert property (!sda_oe_n |-> !sda_out)
		else $error("drives data high");
endmodule // bcc_clock_chk

bind bcc_clock bcc_clock_chk chk (.clk, .rst, .scl_in, .sda_in, .sda_out,
	.sda_oe_n, .supply_lockout, .supply_battery, .battery_mode,
	.bus_locked, .oscillator_halt, .control_reg);

`default_nettype wire

/* test/bcc_master.sv */
// Serial bus master model facing the clock and calendar slave.
`timescale 1ns/1ns
`default_nettype none

module bcc_master (
	// Clock.
	input wire logic clk,
	// Serial pins; sda is the resolved wire level.
	output logic scl,
	output logic sda_m,
	input wire logic sda,
	// One result per byte: data read or the acknowledge bit.
	output logic res_valid,
	output logic [7:0] res
);
	// Idle bus: both lines released high.
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		res_valid = 1'b0;
		res = 8'h00;
	end

	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	task start;
		sda_m <= 1'b0;
		wt(5);
		scl <= 1'b0;
	endtask

	task stop;
		wt(1);
		sda_m <= 1'b0;
		wt(4);
		scl <= 1'b1;
		wt(5);
		sda_m <= 1'b1;
		wt(5);
	endtask

	// Data moves a cycle after the fall so it never looks like a frame edge.
	task bit_io(input logic b, output logic r);
		wt(1);
		sda_m <= b;
		wt(4);
		scl <= 1'b1;
		wt(3);
		r = sda;
		scl <= 1'b0;
	endtask

	task xbyte(input logic [7:0] b, input logic rd, input logic nack);
		logic [7:0] v;
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(rd | b[i], v[i]);
		end
		bit_io(rd ? nack : 1'b1, r);
		res <= rd ? v : {7'h00, ~r};
		res_valid <= 1'b1;
		wt(1);
		res_valid <= 1'b0;
	endtask
endmodule // bcc_master

`default_nettype wire
